// *** core/fdm_defs.vh ***
// Constants for the fieldbus data set mapper
`ifndef FDM_DEFS_VH
`define FDM_DEFS_VH
// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define FDM_REG_CTRL       12'h000
`define FDM_REG_LOSS_DLY   12'h004
`define FDM_REG_TGT_A      12'h008
`define FDM_REG_TGT_B      12'h00C
`define FDM_REG_TGT_C      12'h010
`define FDM_REG_SEL_B      12'h014
`define FDM_REG_SEL_C      12'h018
`define FDM_REG_SEL_D      12'h01C
`define FDM_REG_SEL_E      12'h020
`define FDM_REG_SEL_F      12'h024
`define FDM_REG_STATUS     12'h028
`define FDM_REG_IRQ_STAT   12'h02C
`define FDM_REG_IRQ_MASK   12'h030
`define FDM_REG_IN_AB      12'h034
`define FDM_REG_IN_C       12'h038
// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define FDM_CTRL_RELAY1    0
`define FDM_CTRL_RELAY2    1
`define FDM_CTRL_RELAY3    2
`define FDM_CTRL_ANALOG1   3
`define FDM_CTRL_ANALOG2   4
`define FDM_CTRL_OUTSEL    5
`define FDM_CTRL_ACT_LO    6
`define FDM_CTRL_ACT_HI    7
// ----------------------------------------------------------------------------
// Loss actions and field values
// ----------------------------------------------------------------------------
`define FDM_ACT_NONE       2'h0
`define FDM_ACT_FAULT      2'h1
`define FDM_ACT_FIXED      2'h2
`define FDM_ACT_HOLD       2'h3
`define FDM_RELAY_BIT_A    13
`define FDM_RELAY_BIT_B    14
`define FDM_RELAY_BIT_C    15
`define FDM_ANALOG_FULL    16'h4E20
`define FDM_STATUS_SIG     14'h012E
`define FDM_DEF_SEL_B      14'h0066
`define FDM_DEF_SEL_C      14'h0069
`define FDM_DEF_SEL_D      14'h0131
`define FDM_DEF_SEL_E      14'h0134
`define FDM_DEF_SEL_F      14'h0132
`define FDM_TGT_MAX        14'h2327
`define FDM_SEL_MAX        14'h270F
`define FDM_GRP_MIN        7'h0A
`define FDM_GRP_MAX        7'h59
// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define FDM_CLK_HZ         100000000
`define FDM_TICK_MS        100
`define FDM_TICK_CYC       (`FDM_CLK_HZ / 1000 * `FDM_TICK_MS / 1000)
`define FDM_DLY_MIN        10'h001
`define FDM_DLY_MAX        10'h258
`define FDM_DLY_RESET      10'h001
`endif

// *** core/fdm_mapper.v ***
// Fieldbus data set mapper
//
// Contract
// - Relays follow bits 13..15 of word one
// - Analogue one follows word two, 20000 full
// - Analogue two follows word three, same scale
// - Loss applies one configured drive action
// - Loss detected from data set 1 writes
// - Loss action waits 0.1 to 60 s; the default TICK_CYC of 10000 gives 0.1 to 60 ms
// - On loss outputs go zero or hold
// - Inbound words written to configured parameter
// - Target number is group*100+index, 10..89
// - Outbound word one of set 2 is always status 302
// - Outbound words select signal 0..9999
// - Defaults 102 and 105 for set 2
// - Defaults 305, 308, 306 for set 4
// - Each data set holds three 16-bit words
// - Sets 1/2 every 12 ms, 3/4 100 ms
//
// The address map and the APB slave port were decided locally.
`timescale 1ns/100ps
`include "fdm_defs.vh"
module fdm_mapper #(
   parameter TICK_CYC = `FDM_TICK_CYC
) (
   // Clock and reset
   input  wire        CLOCK_IN,
   input  wire        RSTN_IN,
   // APB slave
   input  wire        PSEL_IN,
   input  wire        PENABLE_IN,
   input  wire        PWRITE_IN,
   input  wire [11:0] PADDR_IN,
   input  wire [31:0] PWDATA_IN,
   output reg  [31:0] PRDATA_OUT,
   output wire        PREADY_OUT,
   output reg         PSLVERR_OUT,
   // Inbound data sets from the adapter
   input  wire        SET1_WR_IN,
   input  wire        SET3_WR_IN,
   input  wire [15:0] SET3_WORD_A_IN,
   input  wire [15:0] SET3_WORD_B_IN,
   input  wire [15:0] SET3_WORD_C_IN,
   // Parameter write port
   output reg         PARAM_WR_OUT,
   output reg  [13:0] PARAM_NUM_OUT,
   output reg  [15:0] PARAM_DATA_OUT,
   // Outbound signal lookup
   output reg  [13:0] SIG_NUM_OUT,
   input  wire [15:0] SIG_DATA_IN,
   input  wire        SET2_RD_IN,
   input  wire        SET4_RD_IN,
   output reg  [15:0] OUT_WORD_A_OUT,
   output reg  [15:0] OUT_WORD_B_OUT,
   output reg  [15:0] OUT_WORD_C_OUT,
   // Drive-side outputs
   output reg         RELAY_OUT_FIRST_OUT,
   output reg         RELAY_OUT_SECOND_OUT,
   output reg         RELAY_OUT_THIRD_OUT,
   output reg  [15:0] ANALOG_OUT_FIRST_OUT,
   output reg  [15:0] ANALOG_OUT_SECOND_OUT,
   output reg         LOSS_TRIP_OUT,
   output reg         LOSS_RUN_FIXED_SPEED_OUT,
   output reg         LOSS_HOLD_SPEED_OUT,
   output reg         IRQ_OUT
);

   // ----------------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------------
   function [6:0] grp_of;
      input [13:0] num;
      reg   [13:0] q;
      begin
         q      = num / 14'd100;
         grp_of = q[6:0];
      end
   endfunction

   function tgt_ok;
      input [13:0] num;
      reg   [6:0]  g;
      begin
         g = grp_of(num);
         tgt_ok = (num != 14'h0000) && (num <= `FDM_TGT_MAX) && (g >= `FDM_GRP_MIN) && (g <= `FDM_GRP_MAX);
      end
   endfunction

   function [13:0] sel_clip;
      input [31:0] v;
      begin
         sel_clip = (v[13:0] > `FDM_SEL_MAX) ? `FDM_SEL_MAX : v[13:0];
      end
   endfunction

   // ----------------------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------------------
   reg  [7:0]  ctrl_q;
   reg  [9:0]  dly_q;
   reg  [13:0] tgt_q [0:2];
   reg  [13:0] sel_q [0:4];
   reg  [3:0]  irq_stat_q;
   reg  [3:0]  irq_mask_q;
   reg  [15:0] in_a_q;
   reg  [15:0] in_b_q;
   reg  [15:0] in_c_q;
   reg         lost_q;
   reg  [23:0] tick_cnt_q;
   reg  [9:0]  loss_cnt_q;
   reg  [1:0]  par_idx_q;
   reg         par_busy_q;
   reg  [2:0]  snap_idx_q;
   reg         snap_set4_q;
   reg         snap_busy_q;
   reg  [15:0] snap_q [0:1];
   reg         set4_pend_q;
   reg  [2:0]  s1_sync_q;
   reg  [2:0]  s3_sync_q;
   reg         s1_lvl_q;
   reg         s3_lvl_q;
   reg         ready_q;

   // One wait state, so read data and error stand registered when ready shows
   wire        acc      = PSEL_IN & PENABLE_IN & ~ready_q;
   wire        apb_wr   = PSEL_IN & PENABLE_IN & PWRITE_IN & ready_q;
   wire        apb_rd   = acc & ~PWRITE_IN;
   wire        s1_evt   = s1_sync_q[1] & s1_sync_q[2] & ~s1_lvl_q;
   wire        s3_evt   = s3_sync_q[1] & s3_sync_q[2] & ~s3_lvl_q;
   wire        tick     = (tick_cnt_q == TICK_CYC - 1);
   wire        loss_due = (loss_cnt_q >= dly_q);
   wire [1:0]  act      = ctrl_q[`FDM_CTRL_ACT_HI:`FDM_CTRL_ACT_LO];
   wire [3:0]  evt      = {loss_due & ~lost_q, s3_evt, s1_evt & lost_q, par_busy_q & PARAM_WR_OUT};

   assign PREADY_OUT = ready_q;

   // ----------------------------------------------------------------------------
   // Adapter strobe capture; three stages, level taken once stages two and three agree
   // ----------------------------------------------------------------------------
   always @(posedge CLOCK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         s1_sync_q <= 3'h0;
         s3_sync_q <= 3'h0;
         s1_lvl_q  <= 1'b0;
         s3_lvl_q  <= 1'b0;
      end else begin
         s1_sync_q <= {s1_sync_q[1:0], SET1_WR_IN};
         s3_sync_q <= {s3_sync_q[1:0], SET3_WR_IN};
         s1_lvl_q  <= (s1_sync_q[1] == s1_sync_q[2]) ? s1_sync_q[2] : s1_lvl_q;
         s3_lvl_q  <= (s3_sync_q[1] == s3_sync_q[2]) ? s3_sync_q[2] : s3_lvl_q;
      end
   end

   // ----------------------------------------------------------------------------
   // APB slave
   // ----------------------------------------------------------------------------
   always @(posedge CLOCK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         ctrl_q      <= 8'h00;
         dly_q       <= `FDM_DLY_RESET;
         tgt_q[0]    <= 14'h0000;
         tgt_q[1]    <= 14'h0000;
         tgt_q[2]    <= 14'h0000;
         sel_q[0]    <= `FDM_DEF_SEL_B;
         sel_q[1]    <= `FDM_DEF_SEL_C;
         sel_q[2]    <= `FDM_DEF_SEL_D;
         sel_q[3]    <= `FDM_DEF_SEL_E;
         sel_q[4]    <= `FDM_DEF_SEL_F;
         irq_mask_q  <= 4'h0;
         irq_stat_q  <= 4'h0;
         PRDATA_OUT  <= 32'h00000000;
         PSLVERR_OUT <= 1'b0;
         ready_q     <= 1'b0;
      end else begin
         ready_q     <= acc;
         // Set wins over a simultaneous write-one clear
         irq_stat_q  <= (irq_stat_q & ~((apb_wr && PADDR_IN == `FDM_REG_IRQ_STAT) ? PWDATA_IN[3:0] : 4'h0)) | evt;
         PSLVERR_OUT <= acc && (PADDR_IN > `FDM_REG_IN_C || PADDR_IN[1:0] != 2'h0);
         if (apb_wr) begin
            case (PADDR_IN)
               `FDM_REG_CTRL:     ctrl_q <= PWDATA_IN[7:0];
               // Out-of-range delays clamp rather than fault, so the watch never stalls at zero
               `FDM_REG_LOSS_DLY: dly_q  <= (PWDATA_IN[9:0] < `FDM_DLY_MIN) ? `FDM_DLY_MIN :
                                            (PWDATA_IN[31:10] != 22'h0 || PWDATA_IN[9:0] > `FDM_DLY_MAX) ?
                                            `FDM_DLY_MAX : PWDATA_IN[9:0];
               `FDM_REG_TGT_A:    tgt_q[0] <= (PWDATA_IN[13:0] > `FDM_TGT_MAX) ? `FDM_TGT_MAX : PWDATA_IN[13:0];
               `FDM_REG_TGT_B:    tgt_q[1] <= (PWDATA_IN[13:0] > `FDM_TGT_MAX) ? `FDM_TGT_MAX : PWDATA_IN[13:0];
               `FDM_REG_TGT_C:    tgt_q[2] <= (PWDATA_IN[13:0] > `FDM_TGT_MAX) ? `FDM_TGT_MAX : PWDATA_IN[13:0];
               `FDM_REG_SEL_B:    sel_q[0] <= sel_clip(PWDATA_IN);
               `FDM_REG_SEL_C:    sel_q[1] <= sel_clip(PWDATA_IN);
               `FDM_REG_SEL_D:    sel_q[2] <= sel_clip(PWDATA_IN);
               `FDM_REG_SEL_E:    sel_q[3] <= sel_clip(PWDATA_IN);
               `FDM_REG_SEL_F:    sel_q[4] <= sel_clip(PWDATA_IN);
               `FDM_REG_IRQ_MASK: irq_mask_q <= PWDATA_IN[3:0];
               `FDM_REG_STATUS, `FDM_REG_IRQ_STAT, `FDM_REG_IN_AB, `FDM_REG_IN_C: ;
               default: ;
            endcase
         end
         if (apb_rd) begin
            case (PADDR_IN)
               `FDM_REG_CTRL:     PRDATA_OUT <= {24'h0, ctrl_q};
               `FDM_REG_LOSS_DLY: PRDATA_OUT <= {22'h0, dly_q};
               `FDM_REG_TGT_A:    PRDATA_OUT <= {18'h0, tgt_q[0]};
               `FDM_REG_TGT_B:    PRDATA_OUT <= {18'h0, tgt_q[1]};
               `FDM_REG_TGT_C:    PRDATA_OUT <= {18'h0, tgt_q[2]};
               `FDM_REG_SEL_B:    PRDATA_OUT <= {18'h0, sel_q[0]};
               `FDM_REG_SEL_C:    PRDATA_OUT <= {18'h0, sel_q[1]};
               `FDM_REG_SEL_D:    PRDATA_OUT <= {18'h0, sel_q[2]};
               `FDM_REG_SEL_E:    PRDATA_OUT <= {18'h0, sel_q[3]};
               `FDM_REG_SEL_F:    PRDATA_OUT <= {18'h0, sel_q[4]};
               `FDM_REG_STATUS:   PRDATA_OUT <= {22'h0, loss_cnt_q[7:0], par_busy_q, lost_q};
               `FDM_REG_IRQ_STAT: PRDATA_OUT <= {28'h0, irq_stat_q};
               `FDM_REG_IRQ_MASK: PRDATA_OUT <= {28'h0, irq_mask_q};
               `FDM_REG_IN_AB:    PRDATA_OUT <= {in_b_q, in_a_q};
               `FDM_REG_IN_C:     PRDATA_OUT <= {16'h0, in_c_q};
               default:           PRDATA_OUT <= 32'h00000000;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------------------
   // Loss watch on a 100 us tick (default TICK_CYC of 10000 cycles at 100 MHz)
   // ----------------------------------------------------------------------------
   always @(posedge CLOCK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         tick_cnt_q <= 24'h000000;
         loss_cnt_q <= 10'h000;
         lost_q     <= 1'b0;
         IRQ_OUT    <= 1'b0;
      end else begin
         IRQ_OUT    <= |(irq_stat_q & irq_mask_q);
         tick_cnt_q <= (tick || s1_evt) ? 24'h000000 : tick_cnt_q + 24'h000001;
         if (s1_evt) begin
            loss_cnt_q <= 10'h000;
            lost_q     <= 1'b0;
         end else begin
            if (tick && !loss_due) begin
               loss_cnt_q <= loss_cnt_q + 10'h001;
            end
            if (loss_due) begin
               lost_q <= 1'b1;
            end
         end
      end
   end

   // ----------------------------------------------------------------------------
   // Inbound words and drive outputs
   // ----------------------------------------------------------------------------
   always @(posedge CLOCK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         in_a_q                   <= 16'h0000;
         in_b_q                   <= 16'h0000;
         in_c_q                   <= 16'h0000;
         RELAY_OUT_FIRST_OUT      <= 1'b0;
         RELAY_OUT_SECOND_OUT     <= 1'b0;
         RELAY_OUT_THIRD_OUT      <= 1'b0;
         ANALOG_OUT_FIRST_OUT     <= 16'h0000;
         ANALOG_OUT_SECOND_OUT    <= 16'h0000;
         LOSS_TRIP_OUT            <= 1'b0;
         LOSS_RUN_FIXED_SPEED_OUT <= 1'b0;
         LOSS_HOLD_SPEED_OUT      <= 1'b0;
      end else begin
         if (s3_evt && !lost_q) begin
            in_a_q <= SET3_WORD_A_IN;
            in_b_q <= SET3_WORD_B_IN;
            in_c_q <= SET3_WORD_C_IN;
         end
         LOSS_TRIP_OUT            <= lost_q && act == `FDM_ACT_FAULT;
         LOSS_RUN_FIXED_SPEED_OUT <= lost_q && act == `FDM_ACT_FIXED;
         LOSS_HOLD_SPEED_OUT      <= lost_q && act == `FDM_ACT_HOLD;
         // Zero mode clears only fieldbus-sourced outputs; hold mode simply keeps captured words
         if (lost_q && !ctrl_q[`FDM_CTRL_OUTSEL]) begin
            RELAY_OUT_FIRST_OUT   <= 1'b0;
            RELAY_OUT_SECOND_OUT  <= 1'b0;
            RELAY_OUT_THIRD_OUT   <= 1'b0;
            ANALOG_OUT_FIRST_OUT  <= 16'h0000;
            ANALOG_OUT_SECOND_OUT <= 16'h0000;
         end else begin
            RELAY_OUT_FIRST_OUT   <= ctrl_q[`FDM_CTRL_RELAY1] & in_a_q[`FDM_RELAY_BIT_A];
            RELAY_OUT_SECOND_OUT  <= ctrl_q[`FDM_CTRL_RELAY2] & in_a_q[`FDM_RELAY_BIT_B];
            RELAY_OUT_THIRD_OUT   <= ctrl_q[`FDM_CTRL_RELAY3] & in_a_q[`FDM_RELAY_BIT_C];
            ANALOG_OUT_FIRST_OUT  <= ctrl_q[`FDM_CTRL_ANALOG1] ? in_b_q : 16'h0000;
            ANALOG_OUT_SECOND_OUT <= ctrl_q[`FDM_CTRL_ANALOG2] ? in_c_q : 16'h0000;
         end
      end
   end

   // ----------------------------------------------------------------------------
   // Parameter writes, one word per cycle after each data set 3 taken while the link is not lost
   // ----------------------------------------------------------------------------
   always @(posedge CLOCK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         par_busy_q     <= 1'b0;
         par_idx_q      <= 2'h0;
         PARAM_WR_OUT   <= 1'b0;
         PARAM_NUM_OUT  <= 14'h0000;
         PARAM_DATA_OUT <= 16'h0000;
      end else begin
         PARAM_WR_OUT <= 1'b0;
         if (s3_evt && !lost_q) begin
            par_busy_q <= 1'b1;
            par_idx_q  <= 2'h0;
         end else if (par_busy_q) begin
            PARAM_WR_OUT   <= tgt_ok(tgt_q[par_idx_q]);
            PARAM_NUM_OUT  <= tgt_q[par_idx_q];
            PARAM_DATA_OUT <= (par_idx_q == 2'h0) ? in_a_q : (par_idx_q == 2'h1) ? in_b_q : in_c_q;
            par_idx_q      <= par_idx_q + 2'h1;
            par_busy_q     <= (par_idx_q != 2'h2);
         end
      end
   end

   // ----------------------------------------------------------------------------
   // Outbound words: status fixed, others looked up one per cycle on request
   // ----------------------------------------------------------------------------
   // The lookup answers combinationally in the same cycle, so each word costs one cycle
   always @(posedge CLOCK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         snap_busy_q    <= 1'b0;
         snap_set4_q    <= 1'b0;
         snap_idx_q     <= 3'h0;
         set4_pend_q    <= 1'b0;
         snap_q[0]      <= 16'h0000;
         snap_q[1]      <= 16'h0000;
         SIG_NUM_OUT    <= `FDM_STATUS_SIG;
         OUT_WORD_A_OUT <= 16'h0000;
         OUT_WORD_B_OUT <= 16'h0000;
         OUT_WORD_C_OUT <= 16'h0000;
      end else begin
         if (SET4_RD_IN) begin
            set4_pend_q <= 1'b1;
         end
         if (!snap_busy_q) begin
            if (SET2_RD_IN) begin
               snap_busy_q <= 1'b1;
               snap_set4_q <= 1'b0;
               snap_idx_q  <= 3'h0;
               SIG_NUM_OUT <= `FDM_STATUS_SIG;
            end else if (set4_pend_q || SET4_RD_IN) begin
               set4_pend_q <= 1'b0;
               snap_busy_q <= 1'b1;
               snap_set4_q <= 1'b1;
               snap_idx_q  <= 3'h0;
               SIG_NUM_OUT <= sel_q[2];
            end
         end else begin
            if (snap_idx_q != 3'h2) begin
               snap_q[snap_idx_q[0]] <= SIG_DATA_IN;
               SIG_NUM_OUT <= snap_set4_q ? sel_q[3'h3 + snap_idx_q] : sel_q[snap_idx_q];
               snap_idx_q  <= snap_idx_q + 3'h1;
            end else begin
               snap_busy_q    <= 1'b0;
               OUT_WORD_A_OUT <= snap_q[0];
               OUT_WORD_B_OUT <= snap_q[1];
               OUT_WORD_C_OUT <= SIG_DATA_IN;
            end
         end
      end
   end

endmodule

// *** verif/fdm_adapter_model.sv ***
// Adapter-side model: data set strobes, inbound words and signal lookup
`timescale 1ns/100ps
module fdm_adapter_model (
   // Clock and control
   input  wire        clk_in,
   input  wire        hb_en_in,
   // Signal lookup
   input  wire [13:0] sig_num_in,
   output wire [15:0] sig_data_out,
   // Data set strobes and words
   output reg         set1_wr_out,
   output reg         set3_wr_out,
   output reg  [15:0] word_a_out,
   output reg  [15:0] word_b_out,
   output reg  [15:0] word_c_out
);
   // Answer at once; pattern keeps every number distinct
   assign sig_data_out = {2'h0, sig_num_in} ^ 16'h5A00;
   initial begin
      set1_wr_out = 1'b0;
      set3_wr_out = 1'b0;
      {word_a_out, word_b_out, word_c_out} = 48'h0;
      forever begin
         @(posedge clk_in);
         if (hb_en_in) begin
            set1_wr_out <= 1'b1;
            repeat (4) @(posedge clk_in);
            set1_wr_out <= 1'b0;
            repeat (3) @(posedge clk_in);
         end
      end
   end
   task send_set3(input [15:0] a, input [15:0] b, input [15:0] c);
      @(posedge clk_in);
      {word_a_out, word_b_out, word_c_out} <= {a, b, c};
      set3_wr_out <= 1'b1;
      repeat (4) @(posedge clk_in);
      set3_wr_out <= 1'b0;
      repeat (2) @(posedge clk_in);
      {word_a_out, word_b_out, word_c_out} <= ~{a, b, c};
      repeat (3) @(posedge clk_in);
   endtask
endmodule

// *** verif/fdm_mapper_properties.sv ***
// Checker for the fieldbus data set mapper ports
`timescale 1ns/100ps
module fdm_mapper_properties #(
   parameter TICK_CYC = 10
) (
   // Clock, reset and bus
   input wire        CLOCK_IN,
   input wire        RSTN_IN,
   input wire        PSEL_IN,
   input wire        PENABLE_IN,
   input wire [11:0] PADDR_IN,
   input wire        PSLVERR_OUT,
   input wire        PREADY_OUT,
   // Link side
   input wire        SET1_WR_IN,
   input wire        SET3_WR_IN,
   input wire [15:0] SET3_WORD_A_IN,
   input wire [15:0] SET3_WORD_B_IN,
   input wire [15:0] SET3_WORD_C_IN,
   input wire        SET2_RD_IN,
   input wire [13:0] SIG_NUM_OUT,
   input wire [15:0] OUT_WORD_A_OUT,
   // Drive side
   input wire        PARAM_WR_OUT,
   input wire [13:0] PARAM_NUM_OUT,
   input wire [15:0] PARAM_DATA_OUT,
   input wire        RELAY_OUT_FIRST_OUT,
   input wire [15:0] ANALOG_OUT_FIRST_OUT,
   input wire [15:0] ANALOG_OUT_SECOND_OUT,
   input wire        LOSS_TRIP_OUT,
   input wire        LOSS_RUN_FIXED_SPEED_OUT,
   input wire        LOSS_HOLD_SPEED_OUT
);
   reg  [15:0] wa_q, wb_q, wc_q;
   reg  [9:0]  since_q;
   wire        lost = LOSS_TRIP_OUT | LOSS_RUN_FIXED_SPEED_OUT | LOSS_HOLD_SPEED_OUT;
   default clocking cb @(posedge CLOCK_IN); endclocking
   default disable iff (!RSTN_IN);
   // Latch words at the strobe; the adapter garbles them later
   always @(posedge CLOCK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         {wa_q, wb_q, wc_q} <= 48'h0;
         since_q <= 10'h0;
      end else begin
         if (SET3_WR_IN && !$past(SET3_WR_IN))
            {wa_q, wb_q, wc_q} <= {SET3_WORD_A_IN, SET3_WORD_B_IN, SET3_WORD_C_IN};
         since_q <= SET1_WR_IN ? 10'h0 : (since_q == 10'h3FF ? since_q : since_q + 10'h1);
      end
   end
   property p_relay; $rose(RELAY_OUT_FIRST_OUT) |-> wa_q[13]; endproperty
   a_relay: assert property (p_relay) else $error("relay one rose with word bit clear");
   property p_ana1; $changed(ANALOG_OUT_FIRST_OUT) && ANALOG_OUT_FIRST_OUT != 16'h0 |-> ANALOG_OUT_FIRST_OUT == wb_q; endproperty
   a_ana1: assert property (p_ana1) else $error("analogue one differs from word two");
   property p_ana2; $changed(ANALOG_OUT_SECOND_OUT) && ANALOG_OUT_SECOND_OUT != 16'h0 |-> ANALOG_OUT_SECOND_OUT == wc_q; endproperty
   a_ana2: assert property (p_ana2) else $error("analogue two differs from word three");
   property p_param; PARAM_WR_OUT |-> PARAM_NUM_OUT >= 14'h03E8 && PARAM_NUM_OUT <= 14'h2327
      && (PARAM_DATA_OUT == wa_q || PARAM_DATA_OUT == wb_q || PARAM_DATA_OUT == wc_q); endproperty
   a_param: assert property (p_param) else $error("parameter write to bad target or data");
   property p_onehot; $onehot0({LOSS_TRIP_OUT, LOSS_RUN_FIXED_SPEED_OUT, LOSS_HOLD_SPEED_OUT}); endproperty
   a_onehot: assert property (p_onehot) else $error("more than one loss action");
   property p_restart; $rose(lost) |-> since_q > 10'd3; endproperty
   a_restart: assert property (p_restart) else $error("loss declared right after a set one write");
   property p_clear; $rose(SET1_WR_IN) |-> ##[1:8] !lost; endproperty
   a_clear: assert property (p_clear) else $error("set one write did not clear loss");
   property p_status; SET2_RD_IN |-> ##[1:3] SIG_NUM_OUT == 14'h012E; endproperty
   a_status: assert property (p_status) else $error("status signal not requested");
   property p_out; SET2_RD_IN |-> ##[3:4] OUT_WORD_A_OUT == 16'h5B2E; endproperty
   a_out: assert property (p_out) else $error("outbound word one is not the status word");
   property p_slverr; PSEL_IN && PENABLE_IN && PADDR_IN >= 12'h03C |-> PSLVERR_OUT == PREADY_OUT; endproperty
   a_slverr: assert property (p_slverr) else $error("unmapped access not flagged");
endmodule

// *** verif/testbench.sv ***
// Self-checking bench for the fieldbus data set mapper
`timescale 1ns/100ps
`include "fdm_defs.vh"
module testbench;
   reg         clk, rst_n, psel, penable, pwrite, set2_rd, set4_rd, hb_en, er;
   reg  [11:0] paddr;
   reg  [31:0] pwdata, rd;
   reg  [13:0] pw_num;
   reg  [15:0] pw_dat;
   reg  [1:0]  a;
   wire [31:0] prdata;
   wire        pready, pslverr, set1_wr, set3_wr, param_wr, rl_a, rl_b, rl_c, trip, fixed, hold, irq;
   wire [15:0] w_a, w_b, w_c, sig_data, param_data, o_a, o_b, o_c, an1, an2;
   wire [13:0] param_num, sig_num;
   integer     err_count, compares, pw_n, k;
   fdm_mapper #(.TICK_CYC(10)) dut_u (.CLOCK_IN(clk), .RSTN_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(penable),
      .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
      .PSLVERR_OUT(pslverr), .SET1_WR_IN(set1_wr), .SET3_WR_IN(set3_wr), .SET3_WORD_A_IN(w_a),
      .SET3_WORD_B_IN(w_b), .SET3_WORD_C_IN(w_c), .PARAM_WR_OUT(param_wr), .PARAM_NUM_OUT(param_num),
      .PARAM_DATA_OUT(param_data), .SIG_NUM_OUT(sig_num), .SIG_DATA_IN(sig_data), .SET2_RD_IN(set2_rd),
      .SET4_RD_IN(set4_rd), .OUT_WORD_A_OUT(o_a), .OUT_WORD_B_OUT(o_b), .OUT_WORD_C_OUT(o_c),
      .RELAY_OUT_FIRST_OUT(rl_a), .RELAY_OUT_SECOND_OUT(rl_b), .RELAY_OUT_THIRD_OUT(rl_c),
      .ANALOG_OUT_FIRST_OUT(an1), .ANALOG_OUT_SECOND_OUT(an2), .LOSS_TRIP_OUT(trip),
      .LOSS_RUN_FIXED_SPEED_OUT(fixed), .LOSS_HOLD_SPEED_OUT(hold), .IRQ_OUT(irq));
   fdm_adapter_model model_u (.clk_in(clk), .hb_en_in(hb_en), .sig_num_in(sig_num), .sig_data_out(sig_data),
      .set1_wr_out(set1_wr), .set3_wr_out(set3_wr), .word_a_out(w_a), .word_b_out(w_b), .word_c_out(w_c));
   function [15:0] fsig(input [13:0] n);
      fsig = {2'h0, n} ^ 16'h5A00;
   endfunction
   task check(input [63:0] got, input [63:0] exp);
      compares = compares + 1;
      if (got !== exp) begin
         err_count = err_count + 1;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task xfer(input w, input [11:0] ad, input [31:0] d);
      @(posedge clk);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, ad, d};
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      er = pslverr;
      {psel, penable} <= 2'h0;
   endtask
   task get(input [11:0] ad);
      xfer(1'b0, ad, 32'h0);
   endtask
   task cyc(input integer n);
      repeat (n) @(posedge clk);
   endtask
   task pulse(input s2);
      @(posedge clk);
      {set2_rd, set4_rd} <= {s2, !s2};
      @(posedge clk);
      {set2_rd, set4_rd} <= 2'h0;
      cyc(6);
   endtask
   task t_regs;
      get(`FDM_REG_SEL_B); check(rd, 32'd102);
      get(`FDM_REG_SEL_C); check(rd, 32'd105);
      get(`FDM_REG_SEL_D); check(rd, 32'd305);
      get(`FDM_REG_SEL_E); check(rd, 32'd308);
      get(`FDM_REG_SEL_F); check(rd, 32'd306);
      get(`FDM_REG_TGT_A); check(rd, 32'd0);
      get(`FDM_REG_LOSS_DLY); check(rd, 32'd1);
      xfer(1'b1, `FDM_REG_LOSS_DLY, 32'd601);
      get(`FDM_REG_LOSS_DLY); check(rd, 32'd600);
      xfer(1'b1, `FDM_REG_LOSS_DLY, 32'd0);
      get(`FDM_REG_LOSS_DLY); check(rd, 32'd1);
      xfer(1'b1, `FDM_REG_SEL_B, 32'd10000);
      get(`FDM_REG_SEL_B); check(rd, 32'd9999);
      get(12'h03C); check({31'h0, er}, 32'h1);
      $display("test regs done");
   endtask
   task t_out;
      xfer(1'b1, `FDM_REG_SEL_B, 32'd102);
      pulse(1'b1);
      check({o_a, o_b, o_c}, {fsig(14'd302), fsig(14'd102), fsig(14'd105)});
      pulse(1'b0);
      check({o_a, o_b, o_c}, {fsig(14'd305), fsig(14'd308), fsig(14'd306)});
      xfer(1'b1, `FDM_REG_SEL_C, 32'd2202);
      pulse(1'b1);
      check({o_a, o_c}, {fsig(14'd302), fsig(14'd2202)});
      $display("test outbound done");
   endtask
   task t_in;
      xfer(1'b1, `FDM_REG_CTRL, 32'h1F);
      xfer(1'b1, `FDM_REG_TGT_A, 32'd3001);
      xfer(1'b1, `FDM_REG_TGT_B, 32'd905);
      model_u.send_set3(16'hA000, 16'h4E20, 16'h1234);
      check({pw_n, 2'h0, pw_num, pw_dat}, {32'd1, 16'd3001, 16'hA000});
      check({rl_a, rl_b, rl_c, an1, an2}, {3'h5, 16'h4E20, 16'h1234});
      xfer(1'b1, `FDM_REG_TGT_C, 32'd8999);
      model_u.send_set3(16'h4000, 16'h0000, 16'h0FFF);
      check({pw_n, 2'h0, pw_num, pw_dat}, {32'd3, 16'd8999, 16'h0FFF});
      check({rl_a, rl_b, rl_c, an1, an2}, {3'h2, 16'h0, 16'h0FFF});
      $display("test inbound done");
   endtask
   task t_loss;
      for (k = 0; k < 4; k = k + 1) begin
         a = k;
         xfer(1'b1, `FDM_REG_CTRL, {24'h0, a, a[0], 5'h1F});
         xfer(1'b1, `FDM_REG_LOSS_DLY, 32'd3);
         xfer(1'b1, `FDM_REG_IRQ_STAT, 32'hF);
         xfer(1'b1, `FDM_REG_IRQ_MASK, (a == 2'h0) ? 32'h0 : 32'h8);
         @(posedge set1_wr);
         hb_en = 1'b0;
         cyc(18);
         check({trip, fixed, hold}, 3'h0);
         cyc(40);
         check({trip, fixed, hold}, (a == 2'h0) ? 3'h0 : 3'h4 >> (a - 2'h1));
         check({rl_a, rl_b, rl_c, an1, an2}, a[0] ? {3'h2, 16'h0, 16'h0FFF} : 35'h0);
         check(irq, a != 2'h0);
         xfer(1'b1, `FDM_REG_IRQ_STAT, 32'h8);
         cyc(2);
         check(irq, 1'b0);
         hb_en = 1'b1;
         cyc(30);
         check({trip, fixed, hold}, 3'h0);
      end
      $display("test loss done");
   endtask
   task stop_test;
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   always @(posedge clk) begin
      if (param_wr === 1'b1) begin
         pw_n <= pw_n + 1;
         pw_num <= param_num;
         pw_dat <= param_data;
      end
   end
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Wide margin over a run of several hundred cycles
   initial begin
      #200000;
      err_count = err_count + 1;
      stop_test;
   end
   initial begin
      {rst_n, psel, penable, pwrite, set2_rd, set4_rd, hb_en} = 7'h0;
      {paddr, pwdata, pw_num, pw_dat} = 74'h0;
      {err_count, compares, pw_n} = 96'h0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      t_regs;
      xfer(1'b1, `FDM_REG_LOSS_DLY, 32'd10);
      hb_en = 1'b1;
      cyc(40);
      t_out;
      t_in;
      t_loss;
      stop_test;
   end
endmodule
bind fdm_mapper fdm_mapper_properties #(.TICK_CYC(TICK_CYC)) chk_u (.*);
